/* File: pkg/plfs_defines.vh */
/*
  Constants for the powerline frame sequencer: timing counts, interface
  select codes, buffer sizes, packet size and arbitration pattern count.
  Assumes a 10 MHz ref_clk; counts are derived from times in microseconds.
*/
`ifndef PLFS_DEFINES_VH
`define PLFS_DEFINES_VH

// -------------------------------------------------------------------
// Clock rate and section times.
// -------------------------------------------------------------------
`define PLFS_CLK_MHZ 10
`define PLFS_PREAMBLE_US 64
`define PLFS_ARB_US 105
`define PLFS_PKT_SHORT_US 180
`define PLFS_PKT_LONG_US 360
`define PLFS_PREAMBLE_CYC (`PLFS_PREAMBLE_US * `PLFS_CLK_MHZ)
`define PLFS_ARB_CYC (`PLFS_ARB_US * `PLFS_CLK_MHZ)
`define PLFS_PKT_SHORT_CYC (`PLFS_PKT_SHORT_US * `PLFS_CLK_MHZ)
`define PLFS_PKT_LONG_CYC (`PLFS_PKT_LONG_US * `PLFS_CLK_MHZ)
`define PLFS_TCNT_W 12

// -------------------------------------------------------------------
// Packet size in bytes and arbitration pattern count.
// -------------------------------------------------------------------
`define PLFS_PKT_BYTES 8'h10
`define PLFS_ARB_PATTERNS 2'h2

// -------------------------------------------------------------------
// Host interface select codes.
// -------------------------------------------------------------------
`define PLFS_IF_UART 2'h0
`define PLFS_IF_RSVD 2'h1
`define PLFS_IF_SPI 2'h2
`define PLFS_IF_I2C 2'h3

// -------------------------------------------------------------------
// Buffers.
// -------------------------------------------------------------------
`define PLFS_BUF_DEPTH 1024
`define PLFS_BUF_AW 10

`endif

/* File: design/plfs_byte_buffer.v */
/*
  Byte buffer of 1024 entries with valid/ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`include "plfs_defines.vh"
`timescale 1ns/1ps

module plfs_byte_buffer (
  // Clock and reset.
  input wire ref_clk,
  input wire rst_b,
  // Write side.
  input wire wr_valid,
  output wire wr_ready,
  input wire [7:0] wr_data,
  // Read side.
  output wire rd_valid,
  input wire rd_ready,
  output wire [7:0] rd_data,
  // Status.
  output wire empty,
  output wire full
);

  // Storage array; the head byte is shown directly from the array.
  reg [7:0] mem [0:`PLFS_BUF_DEPTH-1];
  reg [`PLFS_BUF_AW-1:0] wp_reg;
  reg [`PLFS_BUF_AW-1:0] rp_reg;
  reg [`PLFS_BUF_AW:0] cnt_reg;
  wire do_wr;
  wire do_rd;

  assign empty = (cnt_reg == {(`PLFS_BUF_AW+1){1'b0}});
  assign full = cnt_reg[`PLFS_BUF_AW];
  assign wr_ready = ~full;
  assign rd_valid = ~empty;
  assign rd_data = mem[rp_reg];
  assign do_wr = wr_valid & ~full;
  assign do_rd = rd_ready & ~empty;

  // -------------------------------------------------------------------
  // Pointer and count update.
  // -------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      wp_reg <= {`PLFS_BUF_AW{1'b0}};
      rp_reg <= {`PLFS_BUF_AW{1'b0}};
      cnt_reg <= {(`PLFS_BUF_AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (do_rd) begin
        rp_reg <= rp_reg + 1'b1;
      end
      // Simultaneous read and write leave the count unchanged.
      if (do_wr && !do_rd) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (do_rd && !do_wr) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  // Array write; no reset is needed for data storage.
  always @(posedge ref_clk) begin
    if (do_wr) begin
      mem[wp_reg] <= wr_data;
    end
  end

endmodule

/* File: design/plfs_sequencer.v */
/*
  Powerline frame sequencer: builds timed frames from host bytes and
  returns decoded powerline bytes to the host through a receive buffer.
  Assumes a 10 MHz clock, synchronous inputs, and an external modem and
  codec that consume packet bytes and report decoded bytes.
*/
//
// Behaviour
// - Frame: start section, packets, end marker.
// - Arbitration patterns precede the preamble.
// - Preamble lasts 64 microseconds.
// - Each arbitration pattern lasts 105 microseconds.
// - Packet 180 us codec 0-1, else 360.
// - Every packet carries codec-chosen error correction.
// - UART: first host byte starts the frame.
// - UART: close when buffer empty, host done.
// - SPI/I2C: transmit command starts the frame.
// - SPI/I2C: frame close indication ends frame.
// - Manual trigger mode defers transmission.
// - Decoded frame bytes enter receive buffer.
// - UART: forward received bytes while buffered.
// - Interface select latched at reset release.
// - Select 00 UART, 01 reserved, 10 SPI.
// - Select 11 means I2C.
// - 1024-byte transmit and receive buffers.
// - Four codecs, 0 to 3, per frame.
`include "plfs_defines.vh"
`timescale 1ns/1ps

module plfs_sequencer (
  // Clock and reset.
  input wire ref_clk,
  input wire rst_b,
  // Configuration pins.
  input wire [1:0] if_sel,
  input wire arb_enable,
  input wire manual_trigger_mode,
  input wire tx_trigger,
  input wire [1:0] codec_sel,
  // Host transmit side.
  input wire host_tx_valid,
  input wire [7:0] host_tx_data,
  input wire host_tx_done,
  input wire host_tx_cmd,
  input wire host_frame_close,
  output wire interrupt_or_ready_to_receive,
  // Host receive side.
  output wire host_rx_valid,
  output wire [7:0] host_rx_data,
  input wire host_rx_cmd,
  // Modem transmit side.
  output reg [3:0] line_section,
  output reg [1:0] line_codec,
  output reg line_ecc_on,
  output reg line_tx_on,
  output wire line_byte_valid,
  output wire [7:0] line_byte,
  input wire line_byte_ready,
  // Modem receive side.
  input wire line_rx_valid,
  input wire [7:0] line_rx_byte,
  // Status.
  output reg [1:0] if_mode,
  output wire if_invalid
);

  // -------------------------------------------------------------------
  // States, one-hot.
  // -------------------------------------------------------------------
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_ARB = 5'h02;
  localparam [4:0] S_PRE = 5'h04;
  localparam [4:0] S_PKT = 5'h08;
  localparam [4:0] S_END = 5'h10;

  // Section widths for the counter, sized to the counter.
  localparam [`PLFS_TCNT_W-1:0] PRE_CYC = `PLFS_PREAMBLE_CYC;
  localparam [`PLFS_TCNT_W-1:0] ARB_CYC = `PLFS_ARB_CYC;
  localparam [`PLFS_TCNT_W-1:0] PKT_S_CYC = `PLFS_PKT_SHORT_CYC;
  localparam [`PLFS_TCNT_W-1:0] PKT_L_CYC = `PLFS_PKT_LONG_CYC;

  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [`PLFS_TCNT_W-1:0] tcnt_reg; // Cycles left in the section.
  reg [1:0] arb_cnt_reg; // Arbitration patterns still to send.
  reg [7:0] pkt_bytes_reg; // Bytes taken into the current packet.
  reg close_reg; // Host asked to close the frame.
  reg start_reg; // A start request is pending.
  reg armed_reg; // Mode was latched on the first edge after reset.
  reg [1:0] codec_reg; // Codec captured for this frame.

  wire tx_empty;
  wire tx_full;
  wire rx_empty;
  wire tx_rd_valid;
  wire is_uart;
  wire sec_done;
  wire pkt_take;
  wire rx_take;
  wire trig_ok;

  assign is_uart = (if_mode == `PLFS_IF_UART);
  assign if_invalid = (if_mode == `PLFS_IF_RSVD);
  assign sec_done = (tcnt_reg == {`PLFS_TCNT_W{1'b0}});
  // Manual trigger holds a ready frame back until the user fires it.
  assign trig_ok = ~manual_trigger_mode | tx_trigger;

  // -------------------------------------------------------------------
  // Buffers.
  // -------------------------------------------------------------------
  // Bytes leave for the modem only during a packet section.
  assign pkt_take = (state_reg == S_PKT) & line_byte_ready & tx_rd_valid &
                    (pkt_bytes_reg != `PLFS_PKT_BYTES);
  assign line_byte_valid = (state_reg == S_PKT) & tx_rd_valid &
                           (pkt_bytes_reg != `PLFS_PKT_BYTES);
  // In UART mode ready tells the host to pause before the buffer overflows; otherwise the pin flags received bytes.
  assign interrupt_or_ready_to_receive = is_uart ? ~tx_full : ~rx_empty;

  plfs_byte_buffer u_tx_buf (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .wr_valid(host_tx_valid & armed_reg & ~if_invalid),
    .wr_ready(),
    .wr_data(host_tx_data),
    .rd_valid(tx_rd_valid),
    .rd_ready(pkt_take),
    .rd_data(line_byte),
    .empty(tx_empty),
    .full(tx_full)
  );

  // UART drains on its own; SPI/I2C only on the read command.
  assign rx_take = is_uart | host_rx_cmd;

  plfs_byte_buffer u_rx_buf (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .wr_valid(line_rx_valid),
    .wr_ready(),
    .wr_data(line_rx_byte),
    .rd_valid(host_rx_valid),
    .rd_ready(rx_take),
    .rd_data(host_rx_data),
    .empty(rx_empty),
    .full()
  );

  // -------------------------------------------------------------------
  // Interface mode latch.
  // -------------------------------------------------------------------
  // Captured once by a clocked process after release; held until reset.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      if_mode <= `PLFS_IF_UART;
      armed_reg <= 1'b0;
    end else if (!armed_reg) begin
      if_mode <= if_sel;
      armed_reg <= 1'b1;
    end
  end

  // -------------------------------------------------------------------
  // Start and close requests.
  // -------------------------------------------------------------------
  // Start requests taken during a frame wait for its end marker; set beats clear.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      start_reg <= 1'b0;
      close_reg <= 1'b0;
    end else begin
      if (armed_reg && is_uart && host_tx_valid) begin
        start_reg <= 1'b1;
      end else if (armed_reg && !is_uart && !if_invalid && host_tx_cmd) begin
        start_reg <= 1'b1;
      end else if (state_reg == S_IDLE && state_next != S_IDLE) begin
        start_reg <= 1'b0;
      end
      // Set wins over clear when both occur together.
      if (host_frame_close && !is_uart) begin
        close_reg <= 1'b1;
      end else if (state_reg == S_END) begin
        close_reg <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------
  // Frame state machine, next state.
  // -------------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        // Reached from reset or after an end marker, so frames never overlap.
        if (start_reg && trig_ok) begin
          state_next = arb_enable ? S_ARB : S_PRE;
        end
      end
      S_ARB: begin
        if (sec_done && arb_cnt_reg == 2'h1) begin
          state_next = S_PRE;
        end
      end
      S_PRE: begin
        if (sec_done) begin
          state_next = S_PKT;
        end
      end
      S_PKT: begin
        // At least one packet; closing checked at each packet boundary.
        if (sec_done) begin
          if (is_uart && tx_empty && host_tx_done) begin
            state_next = S_END;
          end else if (!is_uart && close_reg && tx_empty) begin
            state_next = S_END;
          end
        end
      end
      S_END: begin
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // -------------------------------------------------------------------
  // Frame state machine, registers and section timer.
  // -------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      state_reg <= S_IDLE;
      tcnt_reg <= {`PLFS_TCNT_W{1'b0}};
      arb_cnt_reg <= 2'h0;
      pkt_bytes_reg <= 8'h00;
      codec_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      if (pkt_take) begin
        pkt_bytes_reg <= pkt_bytes_reg + 8'h01;
      end
      if (state_next != state_reg || (state_reg == S_ARB && sec_done) ||
          (state_reg == S_PKT && sec_done)) begin
        pkt_bytes_reg <= 8'h00;
        case (state_next)
          S_ARB: begin
            tcnt_reg <= ARB_CYC - 1'b1;
            arb_cnt_reg <= (state_reg == S_ARB) ? arb_cnt_reg - 2'h1 :
                           `PLFS_ARB_PATTERNS;
          end
          S_PRE: begin
            tcnt_reg <= PRE_CYC - 1'b1;
          end
          S_PKT: begin
            // Codecs 2 and 3 run at half rate, so packets double.
            tcnt_reg <= codec_reg[1] ? PKT_L_CYC - 1'b1 :
                        PKT_S_CYC - 1'b1;
          end
          default: begin
            tcnt_reg <= {`PLFS_TCNT_W{1'b0}};
          end
        endcase
      end else if (!sec_done) begin
        tcnt_reg <= tcnt_reg - 1'b1;
      end
      // Codec is frozen from the edge that starts a frame, so the timer
      // and line_codec always agree.
      if (state_reg == S_IDLE && state_next == S_IDLE) begin
        codec_reg <= codec_sel;
      end
    end
  end

  // -------------------------------------------------------------------
  // Modem-facing outputs.
  // -------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      line_section <= 4'h0;
      line_codec <= 2'h0;
      line_ecc_on <= 1'b0;
      line_tx_on <= 1'b0;
    end else begin
      line_section <= state_next[4:1];
      line_codec <= codec_reg;
      line_ecc_on <= (state_next == S_PKT);
      line_tx_on <= (state_next != S_IDLE);
    end
  end

endmodule

/* File: dv/plfs_monitor.sv */
/* Checker for the frame sequencer's pins.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`include "plfs_defines.vh"
module plfs_monitor (
  // Clock and reset.
  input wire ref_clk,
  input wire rst_b,
  // Pins watched.
  input wire [1:0] if_sel,
  input wire arb_enable,
  input wire manual_trigger_mode,
  input wire tx_trigger,
  input wire [3:0] line_section,
  input wire [1:0] line_codec,
  input wire line_ecc_on,
  input wire line_tx_on,
  input wire [1:0] if_mode,
  input wire if_invalid
);
  // Last section and its length; the 16-bit count outlasts every section this bench drives.
  reg [3:0] prev_reg;
  reg [15:0] run_reg;
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      prev_reg <= 4'h0;
      run_reg <= 16'h0000;
    end else begin
      prev_reg <= line_section;
      run_reg <= (line_section == prev_reg) ? run_reg + 16'h0001 : 16'h0001;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_pre_len;
    prev_reg == 4'h2 && line_section != 4'h2 |->
      run_reg == `PLFS_PREAMBLE_CYC && line_section == 4'h4;
  endproperty
  a_pre_len: assert property (p_pre_len) else $error("preamble length");
  property p_arb_len;
    prev_reg == 4'h1 && line_section != 4'h1 |-> line_section == 4'h2 &&
      (run_reg == `PLFS_ARB_CYC || run_reg == 2 * `PLFS_ARB_CYC);
  endproperty
  a_arb_len: assert property (p_arb_len) else $error("arb length");
  property p_pkt_len;
    prev_reg == 4'h4 && line_section != 4'h4 |-> run_reg % (line_codec[1] ?
      `PLFS_PKT_LONG_CYC : `PLFS_PKT_SHORT_CYC) == 0;
  endproperty
  a_pkt_len: assert property (p_pkt_len) else $error("packet length");
  property p_end_one;
    line_section == 4'h8 |=> line_section inside {4'h0, 4'h1, 4'h2};
  endproperty
  a_end_one: assert property (p_end_one) else $error("end marker");
  property p_start;
    $rose(line_tx_on) |-> line_section == ($past(arb_enable) ? 4'h1 : 4'h2);
  endproperty
  a_start: assert property (p_start) else $error("start section");
  property p_ecc;
    line_ecc_on == (line_section == 4'h4);
  endproperty
  a_ecc: assert property (p_ecc) else $error("ecc flag");
  property p_tx_on;
    line_tx_on == (line_section != 4'h0);
  endproperty
  a_tx_on: assert property (p_tx_on) else $error("tx on");
  property p_mode_latch;
    !$past(rst_b, 2) && $past(rst_b) |-> if_mode == $past(if_sel);
  endproperty
  a_mode_latch: assert property (p_mode_latch) else $error("latch");
  property p_mode_hold;
    $past(rst_b, 2) |-> $stable(if_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
  property p_invalid;
    if_invalid |-> if_mode == 2'h1 && !line_tx_on;
  endproperty
  a_invalid: assert property (p_invalid) else $error("reserved");
  // The trigger is sampled on the edge that leaves idle, the same edge that raises tx-on.
  property p_manual;
    $rose(line_tx_on) && $past(manual_trigger_mode) |-> $past(tx_trigger);
  endproperty
  a_manual: assert property (p_manual) else $error("no trigger");
endmodule
bind plfs_sequencer plfs_monitor u_mon (.ref_clk(ref_clk), .rst_b(rst_b),
  .if_sel(if_sel), .arb_enable(arb_enable), .tx_trigger(tx_trigger),
  .manual_trigger_mode(manual_trigger_mode), .line_codec(line_codec),
  .line_section(line_section), .line_ecc_on(line_ecc_on),
  .line_tx_on(line_tx_on), .if_mode(if_mode), .if_invalid(if_invalid));

/* File: dv/plfs_host_model.sv */
/* Host controller model for the sequencer's host side.
   Assumes the bench calls its tasks just after a rising edge. */
`timescale 1ns/1ps
module plfs_host_model (
  // Clock and reset.
  input wire ref_clk,
  input wire rst_b,
  // Device status.
  input wire [1:0] if_mode,
  input wire interrupt_or_ready_to_receive,
  input wire host_rx_valid,
  input wire [7:0] host_rx_data,
  // Host requests.
  output reg host_tx_valid = 1'b0,
  output reg [7:0] host_tx_data = 8'h00,
  output reg host_tx_cmd = 1'b0,
  output reg host_frame_close = 1'b0,
  output reg host_rx_cmd = 1'b0
);
  // Bytes pulled back, oldest first.
  logic [7:0] rx_q[$];
  // One byte; an edge passes after release so calls never collide.
  task send_byte(input logic [7:0] b);
    while (if_mode == 2'h0 && interrupt_or_ready_to_receive !== 1'b1)
      @(posedge ref_clk);
    host_tx_valid <= 1'b1;
    host_tx_data <= b;
    @(posedge ref_clk);
    host_tx_valid <= 1'b0;
    host_tx_data <= ~b;
    @(posedge ref_clk);
  endtask
  task pulse_cmd;
    host_tx_cmd <= 1'b1;
    @(posedge ref_clk);
    host_tx_cmd <= 1'b0;
    @(posedge ref_clk);
  endtask
  task pulse_close;
    host_frame_close <= 1'b1;
    @(posedge ref_clk);
    host_frame_close <= 1'b0;
    @(posedge ref_clk);
  endtask
  // SPI/I2C modes pull every other cycle so valid has settled after a pop.
  // In UART mode every byte shown is a forwarded byte and is logged too.
  always @(posedge ref_clk) begin
    if (!rst_b)
      rx_q.delete();
    else if (host_rx_cmd || (if_mode == 2'h0 && host_rx_valid === 1'b1))
      rx_q.push_back(host_rx_data);
    host_rx_cmd <= rst_b && host_rx_valid && !host_rx_cmd && if_mode[1];
  end
endmodule

/* File: dv/tb_powerline_frame_sequencer.sv */
/* Self-checking bench for the frame sequencer.
   Assumes the host model beside it and a bound checker. */
`timescale 1ns/1ps
module tb_powerline_frame_sequencer;
  logic ref_clk = 1'b0, rst_b = 1'b0, arb_enable = 1'b0, tx_trigger = 1'b0;
  logic manual_trigger_mode = 1'b0, host_tx_done = 1'b0;
  logic line_byte_ready = 1'b0, line_rx_valid = 1'b0;
  logic [1:0] if_sel = 2'h0, codec_sel = 2'h0;
  logic [7:0] line_rx_byte = 8'h00;
  wire host_tx_valid, host_tx_cmd, host_frame_close, host_rx_cmd, rtr;
  wire host_rx_valid, line_ecc_on, line_tx_on, line_byte_valid, if_invalid;
  wire [7:0] host_tx_data, host_rx_data, line_byte;
  wire [3:0] line_section;
  wire [1:0] line_codec, if_mode;
  integer err_count = 0, n_checks = 0, i, j;
  logic [7:0] exp_q[$];
  always #50 ref_clk = ~ref_clk;
  plfs_sequencer dut (.ref_clk(ref_clk), .rst_b(rst_b), .if_sel(if_sel),
    .arb_enable(arb_enable), .manual_trigger_mode(manual_trigger_mode),
    .tx_trigger(tx_trigger), .codec_sel(codec_sel),
    .host_tx_valid(host_tx_valid), .host_tx_data(host_tx_data),
    .host_tx_done(host_tx_done), .host_tx_cmd(host_tx_cmd),
    .host_frame_close(host_frame_close),
    .interrupt_or_ready_to_receive(rtr), .host_rx_valid(host_rx_valid),
    .host_rx_data(host_rx_data), .host_rx_cmd(host_rx_cmd),
    .line_section(line_section), .line_codec(line_codec),
    .line_ecc_on(line_ecc_on), .line_tx_on(line_tx_on),
    .line_byte_valid(line_byte_valid), .line_byte(line_byte),
    .line_byte_ready(line_byte_ready), .line_rx_valid(line_rx_valid),
    .line_rx_byte(line_rx_byte), .if_mode(if_mode), .if_invalid(if_invalid));
  plfs_host_model host (.ref_clk(ref_clk), .rst_b(rst_b), .if_mode(if_mode),
    .interrupt_or_ready_to_receive(rtr), .host_rx_valid(host_rx_valid),
    .host_rx_data(host_rx_data), .host_tx_valid(host_tx_valid),
    .host_tx_data(host_tx_data), .host_tx_cmd(host_tx_cmd),
    .host_frame_close(host_frame_close), .host_rx_cmd(host_rx_cmd));
  task check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task do_reset(input logic [1:0] sel);
    rst_b <= 1'b0;
    if_sel <= sel;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    if_sel <= ~sel;
    repeat (2) @(negedge ref_clk);
    check(if_mode === sel && if_invalid === (sel == 2'h1), "if mode");
    @(posedge ref_clk);
  endtask
  task put(input logic [7:0] b);
    exp_q.push_back(b);
    host.send_byte(b);
  endtask
  task push_rx(input logic [7:0] b);
    line_rx_valid <= 1'b1;
    line_rx_byte <= b;
    @(posedge ref_clk);
    line_rx_valid <= 1'b0;
    line_rx_byte <= ~b;
    @(posedge ref_clk);
  endtask
  task wait_frame;
    for (i = 0; i < 300 && line_tx_on !== 1'b1; i++) @(posedge ref_clk);
    @(negedge ref_clk);
    check(line_tx_on === 1'b1 && line_codec === codec_sel, "no start");
    for (i = 0; i < 12000 && line_tx_on !== 1'b0; i++) @(posedge ref_clk);
    check(line_tx_on === 1'b0 && exp_q.size() == 0, "no close");
  endtask
  // Modem side stalls every other cycle and checks byte order.
  always @(posedge ref_clk) begin
    line_byte_ready <= ~line_byte_ready;
    if (rst_b && line_byte_valid === 1'b1 && line_byte_ready) begin
      check(exp_q.size() > 0 && line_byte === exp_q[0], "line byte");
      if (exp_q.size() > 0)
        void'(exp_q.pop_front());
    end
  end
  initial begin
    // All frames together take well under 40000 cycles.
    repeat (60000) @(posedge ref_clk);
    err_count++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    close_out;
  end
  initial begin
    for (j = 3; j >= 0; j--) do_reset(j[1:0]);
    host_tx_done <= 1'b1;
    for (j = 0; j < 4; j++) begin
      codec_sel <= j[1:0];
      arb_enable <= j[0];
      @(posedge ref_clk);
      put(8'h40 + j[7:0]);
      wait_frame;
    end
    manual_trigger_mode <= 1'b1;
    put(8'h3c);
    repeat (40) @(posedge ref_clk);
    check(line_tx_on === 1'b0, "manual start");
    tx_trigger <= 1'b1;
    wait_frame;
    manual_trigger_mode <= 1'b0;
    tx_trigger <= 1'b0;
    for (j = 0; j < 2; j++) push_rx(8'h90 + j[7:0]);
    for (i = 0; i < 2000 && host_rx_valid !== 1'b0; i++) @(posedge ref_clk);
    check(host_rx_valid === 1'b0, "uart rx stuck");
    check(host.rx_q.size() == 2, "uart rx count");
    for (j = 0; j < 2; j++)
      check(host.rx_q[j] === 8'h90 + j[7:0], "uart rx byte");
    do_reset(2'h2);
    put(8'h11);
    repeat (30) @(posedge ref_clk);
    check(line_tx_on === 1'b0, "byte alone started");
    host.pulse_cmd;
    put(8'h22);
    host.pulse_close;
    wait_frame;
    push_rx(8'hc0);
    @(negedge ref_clk);
    check(rtr === 1'b1, "no rx interrupt");
    @(posedge ref_clk);
    for (j = 1; j < 3; j++) push_rx(8'hc0 + j[7:0]);
    repeat (20) @(posedge ref_clk);
    check(rtr === 1'b0, "rx interrupt stuck");
    check(host.rx_q.size() == 3, "rx count");
    for (j = 0; j < 3; j++)
      check(host.rx_q[j] === 8'hc0 + j[7:0], "rx byte");
    // I2C behaves as SPI: command opens, close indication ends the frame.
    do_reset(2'h3);
    codec_sel <= 2'h0;
    arb_enable <= 1'b0;
    host.pulse_cmd;
    put(8'h33);
    host.pulse_close;
    wait_frame;
    do_reset(2'h1);
    host.pulse_cmd;
    host.send_byte(8'h77);
    repeat (50) @(posedge ref_clk);
    check(line_tx_on === 1'b0, "reserved sent");
    close_out;
  end
endmodule
